/* rtl/ccp_capture_pkg.sv */
package ccp_capture_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h04;
	localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	// control register layout
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int STEER_BIT = 7;
	localparam int DUTY_LSB = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_WMASK = 8'hbf;
	// flag register layout
	localparam int FLAG_CAPTURE = 5;
	localparam logic [7:0] FLAG_WMASK = 8'h20;
	// mode encodings
	typedef enum logic [3:0] {
		MODE_OFF = 4'h0,
		MODE_FALL = 4'h4,
		MODE_RISE = 4'h5,
		MODE_RISE4 = 4'h6,
		MODE_RISE16 = 4'h7
	} capture_mode_t;
	localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_16_LAST = 4'hf;
	localparam logic [3:0] PRESCALE_ZERO = 4'h0;
	localparam logic [3:0] PRESCALE_ONE = 4'h1;
endpackage

/* rtl/enhanced_ccp_capture_unit.sv */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
module enhanced_ccp_capture_unit
	import ccp_capture_pkg::*;
#(
	parameter int TIMER_W = 16
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic captureInputPin,
	input wire logic [TIMER_W-1:0] timerOneCount,
	output logic irq
);
	// the capture pair holds exactly two bytes of timer count
	if (TIMER_W != 16) begin : g_width_check
		$error("timer width must be 16");
	end

	logic [7:0] control_r;
	logic [7:0] capLow_r;
	logic [7:0] capHigh_r;
	logic capFlag_r;
	logic capMask_r;
	logic pinPrev_r;
	logic [3:0] prescale_r;
	logic [3:0] prescale_nxt;

	// all checks below sample on mclk, quiet during reset
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// bus decode
	wire logic wrStrobe = psel && penable && pwrite;
	wire logic selControl = (paddr == ADDR_CONTROL);
	wire logic selLow = (paddr == ADDR_CAPTURE_LOW);
	wire logic selHigh = (paddr == ADDR_CAPTURE_HIGH);
	wire logic selFlags = (paddr == ADDR_FLAGS);
	wire logic selMask = (paddr == ADDR_MASK);
	wire logic selAny = selControl | selLow | selHigh | selFlags | selMask;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !selAny;

	// mode decode and edge detection
	wire logic [3:0] mode = control_r[MODE_LSB +: MODE_W];
	wire logic isFall = (mode == MODE_FALL);
	wire logic isRise = (mode == MODE_RISE);
	wire logic isRise4 = (mode == MODE_RISE4);
	wire logic isRise16 = (mode == MODE_RISE16);
	wire logic inCapture = isFall | isRise | isRise4 | isRise16;
	wire logic riseEdge = captureInputPin && !pinPrev_r;
	wire logic fallEdge = !captureInputPin && pinPrev_r;
	wire logic [3:0] preLast = isRise4 ? PRESCALE_4_LAST : PRESCALE_16_LAST;
	wire logic preHit = riseEdge && (prescale_r == preLast);
	wire logic preOver = riseEdge && (prescale_r > preLast);
	// divided captures on fourth or sixteenth rising edge, or on the next rising edge if the count is already past the last value
	wire logic divEvent = (isRise4 | isRise16) && (preHit | preOver);
	wire logic captureEvent = (isFall && fallEdge) || (isRise && riseEdge)
		|| divEvent;

	// prescaler: cleared outside capture, kept across prescale changes
	always_comb begin
		prescale_nxt = prescale_r;
		if (!(isRise4 | isRise16)) begin
			prescale_nxt = PRESCALE_ZERO;
		end else if (divEvent) begin
			prescale_nxt = PRESCALE_ZERO;
		end else if (riseEdge) begin
			prescale_nxt = prescale_r + PRESCALE_ONE;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prescale_r <= PRESCALE_ZERO;
			pinPrev_r <= 1'b0;
		end else begin
			prescale_r <= prescale_nxt;
			pinPrev_r <= captureInputPin;
		end
	end

	// control register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			control_r <= CONTROL_RESET;
		end else if (wrStrobe && selControl) begin
			control_r <= pwdata[7:0] & CONTROL_WMASK;
		end
	end

	// capture latch, new value always overwrites
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			capLow_r <= 8'h00;
			capHigh_r <= 8'h00;
		end else if (captureEvent) begin
			capLow_r <= timerOneCount[7:0];
			capHigh_r <= timerOneCount[15:8];
		end
	end

	// sticky flag, set wins over write-one clear
	wire logic flagClear = wrStrobe && selFlags && pwdata[FLAG_CAPTURE];
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			capFlag_r <= 1'b0;
		end else if (captureEvent) begin
			capFlag_r <= 1'b1;
		end else if (flagClear) begin
			capFlag_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			capMask_r <= 1'b0;
		end else if (wrStrobe && selMask) begin
			capMask_r <= pwdata[FLAG_CAPTURE];
		end
	end

	assign irq = capFlag_r && capMask_r;

	// read mux
	wire logic [7:0] flagByte = (8'(capFlag_r) << FLAG_CAPTURE) & FLAG_WMASK;
	wire logic [7:0] maskByte = (8'(capMask_r) << FLAG_CAPTURE) & FLAG_WMASK;
	wire logic [7:0] rdByte = selControl ? control_r :
		selLow ? capLow_r :
		selHigh ? capHigh_r :
		selFlags ? flagByte :
		selMask ? maskByte : 8'h00;
	assign prdata = {24'h000000, rdByte};

	// capture pair gets the timer count of the event cycle
	AST_CAPTURE_VALUE: assert property (
		captureEvent |=> {capHigh_r, capLow_r} == $past(timerOneCount))
		else $error("capture pair does not hold timer count");

	// low byte only moves on a capture
	AST_HOLD_LOW: assert property (
		!captureEvent |=> capLow_r == $past(capLow_r))
		else $error("capture low byte changed without capture");

	// high byte only moves on a capture
	AST_HOLD_HIGH: assert property (
		!captureEvent |=> capHigh_r == $past(capHigh_r))
		else $error("capture high byte changed without capture");

	// pending capture is overwritten, not kept
	AST_OVERWRITE: assert property (
		(captureEvent && capFlag_r) |=> {capHigh_r, capLow_r} == $past(timerOneCount))
		else $error("pending capture not overwritten");

	// falling mode needs a falling edge
	AST_FALL_ONLY: assert property (
		(isFall && captureEvent) |-> fallEdge)
		else $error("falling mode captured without falling edge");

	// every falling edge captures in falling mode
	AST_FALL_CAP: assert property (
		(isFall && fallEdge) |-> captureEvent)
		else $error("falling edge missed");

	// rising mode needs a rising edge
	AST_RISE_ONLY: assert property (
		(isRise && captureEvent) |-> riseEdge)
		else $error("rising mode captured without rising edge");

	// every rising edge captures in rising mode
	AST_RISE_CAP: assert property (
		(isRise && riseEdge) |-> captureEvent)
		else $error("rising edge missed");

	// no divide-by-four capture before the fourth edge
	AST_DIV4: assert property (
		(isRise4 && riseEdge && prescale_r < PRESCALE_4_LAST) |-> !captureEvent)
		else $error("divide by four captured early");

	// fourth rising edge captures
	AST_DIV4_HIT: assert property (
		(isRise4 && riseEdge && prescale_r == PRESCALE_4_LAST) |-> captureEvent)
		else $error("divide by four missed capture");

	// divide-by-four ignores cycles without a rising edge
	AST_DIV4_NOFALL: assert property (
		(isRise4 && !riseEdge) |-> !captureEvent)
		else $error("divide by four captured without rising edge");

	// sixteenth rising edge captures
	AST_DIV16: assert property (
		(isRise16 && riseEdge && prescale_r == PRESCALE_16_LAST) |-> captureEvent)
		else $error("divide by sixteen missed capture");

	// no divide-by-sixteen capture before the sixteenth edge
	AST_DIV16_EARLY: assert property (
		(isRise16 && riseEdge && prescale_r != PRESCALE_16_LAST) |-> !captureEvent)
		else $error("divide by sixteen captured early");

	// divide-by-sixteen ignores cycles without a rising edge
	AST_DIV16_NOFALL: assert property (
		(isRise16 && !riseEdge) |-> !captureEvent)
		else $error("divide by sixteen captured without rising edge");

	// a rising edge that does not capture advances the count
	AST_PRE_COUNT: assert property (
		((isRise4 || isRise16) && riseEdge && !divEvent)
		|=> prescale_r == $past(prescale_r) + PRESCALE_ONE)
		else $error("prescaler did not count rising edge");

	// a divided capture restarts the count
	AST_PRE_WRAP: assert property (
		divEvent |=> prescale_r == PRESCALE_ZERO)
		else $error("prescaler not restarted after capture");

	// flag follows every capture
	AST_FLAG_SET: assert property (
		captureEvent |=> capFlag_r)
		else $error("flag not set on capture");

	// flag never rises without a capture
	AST_FLAG_NO_SET: assert property (
		(!capFlag_r && !captureEvent) |=> !capFlag_r)
		else $error("flag set without capture");

	// flag only leaves through software
	AST_FLAG_HOLD: assert property (
		(capFlag_r && !flagClear) |=> capFlag_r)
		else $error("flag dropped without software clear");

	// write of one clears the flag
	AST_FLAG_CLEAR: assert property (
		(flagClear && !captureEvent) |=> !capFlag_r)
		else $error("flag not cleared by software");

	// capture in the clearing cycle wins
	AST_FLAG_SET_WINS: assert property (
		(flagClear && captureEvent) |=> capFlag_r)
		else $error("clear won over capture");

	// prescaler idle outside capture
	AST_PRE_CLEAR: assert property (
		!inCapture |=> prescale_r == PRESCALE_ZERO)
		else $error("prescaler not cleared outside capture");

	// switch from four to sixteen keeps the count
	AST_PRE_KEEP: assert property (
		($past(isRise4) && isRise16 && !$past(riseEdge))
		|-> prescale_r == $past(prescale_r))
		else $error("prescaler cleared on prescale change");

	// without a rising edge the count stands
	AST_PRE_IDLE: assert property (
		((isRise4 || isRise16) && !riseEdge) |=> prescale_r == $past(prescale_r))
		else $error("prescaler moved without rising edge");

	// unmasked capture raises the interrupt
	AST_IRQ_SET: assert property (
		(captureEvent && capMask_r && !(wrStrobe && selMask)) |=> irq)
		else $error("interrupt missing after unmasked capture");

	// masked flag keeps the interrupt low
	AST_IRQ_MASKED: assert property (
		!capMask_r |-> !irq)
		else $error("interrupt while masked");

	// module off never captures
	AST_OFF_NOCAP: assert property (
		(mode == MODE_OFF) |-> !captureEvent)
		else $error("capture while module off");

	// codes outside the capture set never capture
	AST_NONCAP: assert property (
		!inCapture |-> !captureEvent)
		else $error("capture in non-capture mode");

	// reserved control bit stays zero
	AST_RESERVED: assert property (
		(control_r & ~CONTROL_WMASK) == 8'h00)
		else $error("reserved control bit set");

	// control write lands masked
	AST_CONTROL_WRITE: assert property (
		(wrStrobe && selControl)
		|=> control_r == ($past(pwdata[7:0]) & CONTROL_WMASK))
		else $error("control write lost");

	// mapped places never report an error
	AST_SLVERR_MAPPED: assert property (
		(psel && penable && selAny) |-> !pslverr)
		else $error("error on mapped address");

	// unmapped places read zero
	AST_UNMAPPED_READ: assert property (
		!selAny |-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule

/* testbench/pin_source.sv */
`timescale 1ns/10ps
module pin_source (
	input wire logic mclk,
	output logic pin
);
	// pin moves only on mclk, timer stays synchronous
	initial pin = 1'b0;
	// one level change, then held three cycles
	task automatic edge_to(input logic v);
		@(posedge mclk);
		pin <= v;
		repeat (3) @(posedge mclk);
	endtask
	// n rising edges, each followed by a fall
	task automatic pulses(input int n);
		repeat (n) begin
			edge_to(1'b1);
			edge_to(1'b0);
		end
	endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import ccp_capture_pkg::*;
	logic mclk, resetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, pin, irq, e;
	logic [15:0] tmr;
	int fail_count, checked;
	// start values
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tmr = 16'h0;
		fail_count = 0;
		checked = 0;
	end
	always #5 mclk = ~mclk;
	enhanced_ccp_capture_unit u_dut (.mclk(mclk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .captureInputPin(pin),
		.timerOneCount(tmr), .irq(irq));
	pin_source u_src (.mclk(mclk), .pin(pin));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("BAD %0t no pready", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	// reset values, reserved bit, unmapped place
	task automatic t_regs;
		rd(ADDR_CONTROL, 32'h0);
		rd(ADDR_FLAGS, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(ADDR_CONTROL, 32'hff);
		rd(ADDR_CONTROL, 32'hbf);
		wr(ADDR_CONTROL, 32'h0);
	endtask
	// single edge modes, flag, irq, overwrite
	task automatic t_single;
		wr(ADDR_MASK, 32'h20);
		wr(ADDR_CONTROL, 32'(MODE_FALL));
		u_src.edge_to(1'b1);
		rd(ADDR_FLAGS, 32'h0);
		tmr <= 16'hc35a;
		u_src.edge_to(1'b0);
		rd(ADDR_FLAGS, 32'h20);
		chk({31'h0, irq}, 32'h1);
		tmr <= 16'h7e81;
		u_src.pulses(1);
		rd(ADDR_CAPTURE_LOW, 32'h81);
		rd(ADDR_CAPTURE_HIGH, 32'h7e);
		rd(ADDR_FLAGS, 32'h20);
		wr(ADDR_FLAGS, 32'h20);
		rd(ADDR_FLAGS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(ADDR_CONTROL, 32'(MODE_RISE));
		tmr <= 16'h2468;
		u_src.edge_to(1'b1);
		rd(ADDR_CAPTURE_LOW, 32'h68);
		wr(ADDR_FLAGS, 32'h20);
		u_src.edge_to(1'b0);
		rd(ADDR_FLAGS, 32'h0);
	endtask
	// n-th rising edge capture after a clean start
	task automatic t_presc(input logic [3:0] m, input int n);
		wr(ADDR_CONTROL, 32'h0);
		wr(ADDR_FLAGS, 32'h20);
		wr(ADDR_CONTROL, 32'(m));
		u_src.pulses(n - 1);
		rd(ADDR_FLAGS, 32'h0);
		tmr <= 16'(16'hbe00 + n);
		u_src.pulses(1);
		rd(ADDR_FLAGS, 32'h20);
		rd(ADDR_CAPTURE_LOW, n);
	endtask
	// prescale switch keeps count, mode off clears it
	task automatic t_switch;
		t_presc(MODE_RISE4, 4);
		u_src.pulses(2);
		wr(ADDR_CONTROL, 32'(MODE_RISE16));
		wr(ADDR_FLAGS, 32'h20);
		u_src.pulses(13);
		rd(ADDR_FLAGS, 32'h0);
		u_src.pulses(1);
		rd(ADDR_FLAGS, 32'h20);
		t_presc(MODE_RISE16, 16);
		u_src.pulses(2);
		t_presc(MODE_RISE4, 4);
	endtask
	// reset in mid-run clears registers and prescaler
	task automatic t_reset;
		wr(ADDR_MASK, 32'h20);
		wr(ADDR_CONTROL, 32'(MODE_RISE4));
		u_src.pulses(2);
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd(ADDR_CONTROL, 32'h0);
		rd(ADDR_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(ADDR_CONTROL, 32'(MODE_RISE4));
		u_src.pulses(3);
		rd(ADDR_FLAGS, 32'h0);
		u_src.pulses(1);
		rd(ADDR_FLAGS, 32'h20);
	endtask
	// verdict and end of run
	task automatic results;
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#200000;
		fail_count++;
		results();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_single();
		t_switch();
		t_reset();
		results();
	end
endmodule
